//--- hw/pcs_pkg.sv
// constants and types for the post-configuration startup sequencer
package pcs_pkg;

	// startup clock sources
	typedef enum logic [1:0]
	{
		PCS_SRC_CFG = 2'b00,
		PCS_SRC_USER = 2'b01,
		PCS_SRC_TEST = 2'b10
	} pcs_src_e;

	// security settings
	typedef enum logic [1:0]
	{
		PCS_SEC_OPEN = 2'b00,
		PCS_SEC_NO_RDBK = 2'b01,
		PCS_SEC_LOCK = 2'b10
	} pcs_sec_e;

	// event phase selection codes
	localparam logic [3:0] PCS_PH_ZERO = 4'h0;
	localparam logic [3:0] PCS_PH_ONE = 4'h1;
	localparam logic [3:0] PCS_PH_SIX = 4'h6;
	localparam logic [3:0] PCS_PH_DONE = 4'h7;
	localparam logic [3:0] PCS_PH_KEEP = 4'h8;
	localparam logic [3:0] PCS_PH_NOWAIT = 4'h9;

	// event indices
	localparam int PCS_EV_NUM = 5;
	localparam int PCS_EV_DONE = 0;
	localparam int PCS_EV_OUTEN = 1;
	localparam int PCS_EV_GSR = 2;
	localparam int PCS_EV_GWE = 3;
	localparam int PCS_EV_DLL = 4;

	// phase counters saturate here
	localparam logic [2:0] PCS_CNT_MAX = 3'h7;
	localparam logic [2:0] PCS_CNT_RST = 3'h0;

	// transition criterion
	localparam logic PCS_XFER_LENGTH = 1'b0;

	// readback and user id
	localparam int PCS_RB_W = 32;
	localparam logic [5:0] PCS_RB_CNT_W = 6'h20;
	localparam logic [31:0] PCS_UID_RST = 32'h0000_0000;

	// internal configuration clock rates in mhz
	localparam int PCS_RATE_NUM = 17;
	localparam logic [4:0] PCS_RATE_LAST = 5'h10;
	localparam logic [5:0] PCS_RATE_MHZ [0:PCS_RATE_NUM-1] = '{
		6'h04, 6'h05, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0d, 6'h0f, 6'h14,
		6'h1a, 6'h1e, 6'h22, 6'h29, 6'h2d, 6'h33, 6'h37, 6'h3c};
	localparam logic [4:0] PCS_RATE_RST = 5'h00;

endpackage : pcs_pkg

//--- hw/pcs_startup_seq.sv
// post-configuration startup sequencer with readback and security
module pcs_startup_seq
	import pcs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic user_clk_pin,
	input wire logic test_clk_pin,
	input wire logic rdbk_clk,
	input wire logic [1:0] startup_src,
	input wire logic done_pipe_en,
	input wire logic xfer_sel,
	input wire logic length_count_met,
	input wire logic done_condition,
	input wire logic [3:0] done_phase,
	input wire logic [3:0] outen_phase,
	input wire logic [3:0] gsr_phase,
	input wire logic [3:0] gwe_phase,
	input wire logic [3:0] dll_phase,
	input wire logic [1:0] security,
	input wire logic readback_trigger,
	input wire logic [31:0] readback_word,
	input wire logic reconfig_req,
	input wire logic uid_load,
	input wire logic [31:0] uid_data,
	input wire logic [4:0] rate_sel,
	output logic done_out,
	output logic outputs_enabled,
	output logic gsr_asserted,
	output logic gwe_asserted,
	output logic dll_released,
	output logic readback_refused,
	output logic readback_busy,
	output logic readback_data,
	output logic reconfig_grant,
	output logic [31:0] user_id,
	output logic [5:0] internal_config_osc_mhz
);

	logic started;
	logic [2:0] cfg_cnt;
	logic [2:0] alt_cnt;
	logic usr_s1, usr_s2, usr_s3;
	logic tst_s1, tst_s2, tst_s3;
	logic trg_s1, trg_s2, trg_s3;
	logic alt_edge;
	logic tick;
	logic done_dly;
	logic done_wait;
	logic [PCS_EV_NUM-1:0] ev_act;
	logic [3:0] ev_sel [PCS_EV_NUM];
	logic [PCS_EV_NUM-1:0] ev_hit;
	logic start_cond;
	logic rb_req_tgl;
	logic [31:0] rb_hold;
	logic ack_s1, ack_s2;
	logic rb_pending;
	logic trg_rise;
	logic rb_ok;
	// link domain
	logic lrst_s1, lrst;
	logic req_l1, req_l2, req_l3;
	logic rb_ack_tgl;
	logic [31:0] rb_shift;
	logic [5:0] rb_cnt;

	assign ev_sel[PCS_EV_DONE] = done_phase;
	assign ev_sel[PCS_EV_OUTEN] = outen_phase;
	assign ev_sel[PCS_EV_GSR] = gsr_phase;
	assign ev_sel[PCS_EV_GWE] = gwe_phase;
	assign ev_sel[PCS_EV_DLL] = dll_phase;

	// pin synchronisers, first stage read only by second
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			{usr_s3, usr_s2, usr_s1} <= 3'h0;
			{tst_s3, tst_s2, tst_s1} <= 3'h0;
			{trg_s3, trg_s2, trg_s1} <= 3'h0;
		end
		else
		begin
			{usr_s3, usr_s2, usr_s1} <= {usr_s2, usr_s1, user_clk_pin};
			{tst_s3, tst_s2, tst_s1} <= {tst_s2, tst_s1, test_clk_pin};
			{trg_s3, trg_s2, trg_s1} <= {trg_s2, trg_s1, readback_trigger};
		end
	end

	always_comb
	begin
		case (pcs_src_e'(startup_src))
			PCS_SRC_USER: alt_edge = usr_s2 & ~usr_s3;
			PCS_SRC_TEST: alt_edge = tst_s2 & ~tst_s3;
			default: alt_edge = 1'b0;
		endcase
		tick = (startup_src == PCS_SRC_USER || startup_src == PCS_SRC_TEST) ? alt_edge : 1'b1;
	end

	assign start_cond = (xfer_sel == PCS_XFER_LENGTH) ? length_count_met : done_condition;

	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			started <= 1'b0;
			cfg_cnt <= PCS_CNT_RST;
		end
		else if (!started)
			started <= start_cond;
		else if (cfg_cnt != PCS_CNT_MAX)
			cfg_cnt <= cfg_cnt + 3'h1;
	end

	// alternate clock edges counted from phase one
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			alt_cnt <= PCS_CNT_RST;
		else if (cfg_cnt != PCS_CNT_RST && alt_edge && alt_cnt != PCS_CNT_MAX)
			alt_cnt <= alt_cnt + 3'h1;
	end

	// done pipe delayed one startup tick
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			done_dly <= 1'b0;
		else if (tick)
			done_dly <= ev_act[PCS_EV_DONE];
	end

	assign done_wait = done_pipe_en ? done_dly : ev_act[PCS_EV_DONE];

	always_comb
	begin
		for (int i = 0; i < PCS_EV_NUM; i++)
		begin
			ev_hit[i] = 1'b0;
			if (ev_sel[i] == PCS_PH_ZERO)
				ev_hit[i] = started && (i == PCS_EV_DLL);
			else if (ev_sel[i] == PCS_PH_ONE)
				ev_hit[i] = (cfg_cnt != PCS_CNT_RST);
			else if (ev_sel[i] <= PCS_PH_SIX)
			begin
				if (startup_src == PCS_SRC_USER || startup_src == PCS_SRC_TEST)
					ev_hit[i] = (alt_cnt >= ev_sel[i][2:0]);
				else
					ev_hit[i] = (cfg_cnt >= ev_sel[i][2:0]);
			end
			else if (ev_sel[i] == PCS_PH_DONE)
				ev_hit[i] = done_wait && i != PCS_EV_DONE && i != PCS_EV_DLL;
			else if (ev_sel[i] == PCS_PH_NOWAIT)
				ev_hit[i] = started && (i == PCS_EV_DLL);
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			ev_act <= '0;
		else
		begin
			for (int i = 0; i < PCS_EV_NUM; i++)
			begin
				// keep holds the current level and never sets it
				if (ev_sel[i] == PCS_PH_KEEP)
					ev_act[i] <= ev_act[i];
				// counted phases and no wait skip tick
				else if (ev_sel[i] <= PCS_PH_SIX || ev_sel[i] == PCS_PH_NOWAIT)
					ev_act[i] <= ev_act[i] | ev_hit[i];
				else if (tick)
					ev_act[i] <= ev_act[i] | ev_hit[i];
			end
		end
	end

	// event outputs, inactive polarity before startup
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			done_out <= 1'b0;
			outputs_enabled <= 1'b0;
			gsr_asserted <= 1'b1;
			gwe_asserted <= 1'b1;
			dll_released <= 1'b0;
		end
		else
		begin
			done_out <= ev_act[PCS_EV_DONE];
			outputs_enabled <= ev_act[PCS_EV_OUTEN];
			gsr_asserted <= ~ev_act[PCS_EV_GSR];
			gwe_asserted <= ~ev_act[PCS_EV_GWE];
			dll_released <= ev_act[PCS_EV_DLL];
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			user_id <= PCS_UID_RST;
		else if (uid_load)
			user_id <= uid_data;
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			internal_config_osc_mhz <= PCS_RATE_MHZ[PCS_RATE_RST];
		else if (rate_sel <= PCS_RATE_LAST)
			internal_config_osc_mhz <= PCS_RATE_MHZ[rate_sel];
		else
			internal_config_osc_mhz <= PCS_RATE_MHZ[PCS_RATE_RST];
	end

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			reconfig_grant <= 1'b0;
		else
			reconfig_grant <= reconfig_req && (security != PCS_SEC_LOCK);
	end

	// acknowledge back from link domain
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			{ack_s2, ack_s1} <= 2'h0;
		else
			{ack_s2, ack_s1} <= {ack_s1, rb_ack_tgl};
	end

	assign trg_rise = trg_s2 & ~trg_s3;
	assign rb_pending = rb_req_tgl ^ ack_s2;
	// only the open setting permits readback
	assign rb_ok = (security == PCS_SEC_OPEN) && !rb_pending;

	// accept trigger and hand word across
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			rb_req_tgl <= 1'b0;
			rb_hold <= '0;
			readback_refused <= 1'b0;
		end
		else
		begin
			readback_refused <= trg_rise && !rb_ok;
			if (trg_rise && rb_ok)
			begin
				rb_hold <= readback_word;
				rb_req_tgl <= ~rb_req_tgl;
			end
		end
	end

	// link domain reset and request synchroniser
	always_ff @(posedge rdbk_clk)
	begin
		lrst_s1 <= srst;
		lrst <= lrst_s1;
	end

	always_ff @(posedge rdbk_clk)
	begin
		if (lrst)
			{req_l3, req_l2, req_l1} <= 3'h0;
		else
			{req_l3, req_l2, req_l1} <= {req_l2, req_l1, rb_req_tgl};
	end

	// one bit per link clock edge
	always_ff @(posedge rdbk_clk)
	begin
		if (lrst)
		begin
			rb_shift <= '0;
			rb_cnt <= '0;
			rb_ack_tgl <= 1'b0;
			readback_data <= 1'b0;
			readback_busy <= 1'b0;
		end
		else if (req_l2 ^ req_l3)
		begin
			rb_shift <= rb_hold;
			rb_cnt <= PCS_RB_CNT_W;
			rb_ack_tgl <= req_l2;
			readback_busy <= 1'b1;
		end
		else if (rb_cnt != 6'h00)
		begin
			readback_data <= rb_shift[PCS_RB_W-1];
			rb_shift <= {rb_shift[PCS_RB_W-2:0], 1'b0};
			rb_cnt <= rb_cnt - 6'h01;
			readback_busy <= (rb_cnt != 6'h01);
		end
	end

endmodule : pcs_startup_seq

//--- verif/pcs_startup_seq_properties.sv
// concurrent checks on the startup sequencer ports
module pcs_startup_seq_properties
	import pcs_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [1:0] security,
	input wire logic reconfig_req,
	input wire logic uid_load,
	input wire logic [31:0] uid_data,
	input wire logic [4:0] rate_sel,
	input wire logic done_out,
	input wire logic outputs_enabled,
	input wire logic gsr_asserted,
	input wire logic gwe_asserted,
	input wire logic dll_released,
	input wire logic reconfig_grant,
	input wire logic [31:0] user_id,
	input wire logic [5:0] internal_config_osc_mhz
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	property p_idle;
		$fell(srst) |-> gsr_asserted && gwe_asserted && !done_out && !outputs_enabled && !dll_released;
	endproperty
	a_idle: assert property (p_idle) else $error("events active after reset");
	property p_done;
		done_out |=> done_out;
	endproperty
	a_done: assert property (p_done) else $error("done dropped");
	property p_gsr;
		!gsr_asserted |=> !gsr_asserted;
	endproperty
	a_gsr: assert property (p_gsr) else $error("set/reset came back");
	property p_grant;
		security != PCS_SEC_LOCK |=> reconfig_grant == $past(reconfig_req);
	endproperty
	a_grant: assert property (p_grant) else $error("grant wrong");
	property p_lock;
		security == PCS_SEC_LOCK |=> !reconfig_grant;
	endproperty
	a_lock: assert property (p_lock) else $error("grant while locked");
	property p_osc;
		(rate_sel == 5'h10) [*2] |-> internal_config_osc_mhz == 6'h3c;
	endproperty
	a_osc: assert property (p_osc) else $error("top rate wrong");
	property p_odef;
		(rate_sel > 5'h10) [*2] |-> internal_config_osc_mhz == 6'h04;
	endproperty
	a_odef: assert property (p_odef) else $error("fallback rate wrong");
	property p_uid;
		uid_load |=> user_id == $past(uid_data);
	endproperty
	a_uid: assert property (p_uid) else $error("user id not loaded");
endmodule : pcs_startup_seq_properties

bind pcs_startup_seq pcs_startup_seq_properties u_props (.sys_clk, .srst, .security, .reconfig_req, .uid_load,
	.uid_data, .rate_sel, .done_out, .outputs_enabled, .gsr_asserted, .gwe_asserted, .dll_released,
	.reconfig_grant, .user_id, .internal_config_osc_mhz);

//--- verif/pcs_rdbk_ctrl.sv
// far-side readback controller: gated link clock, serial capture
module pcs_rdbk_ctrl
(
	input wire logic run,
	input wire logic readback_busy,
	input wire logic readback_data,
	output logic rdbk_clk = 1'b0,
	output logic [31:0] captured = 32'h0
);
	timeunit 1ns;
	timeprecision 100ps;
	logic took = 1'b0;
	// free-running while run is high, parks low once run drops
	always #16 if (run || rdbk_clk) rdbk_clk = ~rdbk_clk;
	always @(posedge rdbk_clk) took <= readback_busy;
	always @(negedge rdbk_clk) if (took) captured <= {captured[30:0], readback_data};
endmodule : pcs_rdbk_ctrl

//--- verif/pcs_startup_seq_bench.sv
// self-checking bench for the startup sequencer
module pcs_startup_seq_bench
	import pcs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk, srst, user_clk_pin, test_clk_pin, rdbk_clk, done_pipe_en, xfer_sel, length_count_met;
	logic done_condition, readback_trigger, reconfig_req, uid_load, run, rf, bs;
	logic [1:0] startup_src, security;
	logic [3:0] done_phase, outen_phase, gsr_phase, gwe_phase, dll_phase;
	logic [31:0] readback_word, uid_data, user_id, captured;
	logic [4:0] rate_sel, ev;
	logic done_out, outputs_enabled, gsr_asserted, gwe_asserted, dll_released;
	logic readback_refused, readback_busy, readback_data, reconfig_grant;
	logic [5:0] internal_config_osc_mhz;
	int n_mismatch = 0;
	int check_count = 0;
	int at [5];
	pcs_startup_seq u_dut (.sys_clk, .srst, .user_clk_pin, .test_clk_pin, .rdbk_clk, .startup_src, .done_pipe_en,
		.xfer_sel, .length_count_met, .done_condition, .done_phase, .outen_phase, .gsr_phase, .gwe_phase, .dll_phase,
		.security, .readback_trigger, .readback_word, .reconfig_req, .uid_load, .uid_data, .rate_sel, .done_out,
		.outputs_enabled, .gsr_asserted, .gwe_asserted, .dll_released, .readback_refused, .readback_busy,
		.readback_data, .reconfig_grant, .user_id, .internal_config_osc_mhz);
	pcs_rdbk_ctrl u_far (.run, .readback_busy, .readback_data, .rdbk_clk, .captured);
	initial sys_clk = 1'b0;
	always #12.5 sys_clk = ~sys_clk;
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask : step
	task automatic do_reset;
		srst = 1'b1;
		run = 1'b1;
		step(20);
		srst = 1'b0;
		step(4);
		run = 1'b0;
	endtask : do_reset
	task automatic pulse(input logic on_test);
		user_clk_pin = !on_test;
		test_clk_pin = on_test;
		step(4);
		user_clk_pin = 1'b0;
		test_clk_pin = 1'b0;
		step(4);
	endtask : pulse
	initial
	begin
		{user_clk_pin, test_clk_pin, done_pipe_en, xfer_sel, length_count_met, done_condition} = 6'h0;
		{readback_trigger, reconfig_req, uid_load, startup_src, security, rate_sel} = 12'h0;
		{done_phase, outen_phase, gsr_phase, gwe_phase, dll_phase} = 20'h0;
		readback_word = 32'ha5c3_0f96;
		uid_data = 32'h1357_9bdf;
		// second pass with the done pipe
		for (int p = 0; p < 2; p++)
		begin
			length_count_met = 1'b0;
			done_pipe_en = p[0];
			do_reset();
			chk("idle", {done_out, outputs_enabled, gsr_asserted, gwe_asserted, dll_released}, 5'h06);
			done_phase = PCS_PH_ONE;
			outen_phase = 4'h3;
			gsr_phase = PCS_PH_SIX;
			gwe_phase = PCS_PH_DONE;
			length_count_met = 1'b1;
			at = '{0, 0, 0, 0, 0};
			for (int k = 1; k < 14; k++)
			begin
				step(1);
				ev = {dll_released, !gwe_asserted, !gsr_asserted, outputs_enabled, done_out};
				for (int i = 0; i < 5; i++)
					if (ev[i] === 1'b1 && at[i] == 0)
						at[i] = k;
			end
			chk("done edge", at[0], 4);
			chk("outen edge", at[1], 6);
			chk("gsr edge", at[2], 9);
			chk("gwe order", at[3] > at[0], 1);
			chk("done pipe", at[3] - at[0], 1 + p);
			chk("dll edge", at[4], 3);
		end
		for (int s = 1; s < 3; s++)
		begin
			length_count_met = 1'b0;
			done_condition = 1'b0;
			startup_src = s[1:0];
			xfer_sel = 1'b1;
			do_reset();
			done_condition = 1'b1;
			done_phase = 4'h2;
			outen_phase = PCS_PH_KEEP;
			gsr_phase = PCS_PH_ONE;
			dll_phase = PCS_PH_NOWAIT;
			pulse(s == 1);
			pulse(s == 1);
			chk("other clock", done_out, 1'b0);
			chk("keep", outputs_enabled, 1'b0);
			chk("phase one", gsr_asserted, 1'b0);
			chk("no wait", dll_released, 1'b1);
			pulse(s == 2);
			chk("one edge", done_out, 1'b0);
			pulse(s == 2);
			chk("two edges", done_out, 1'b1);
		end
		for (int s = 0; s < 3; s++)
		begin
			security = s[1:0];
			reconfig_req = 1'b1;
			step(2);
			chk("grant", reconfig_grant, s != 2);
			reconfig_req = 1'b0;
			readback_trigger = 1'b1;
			run = 1'b1;
			{rf, bs} = 2'h0;
			repeat (80)
			begin
				step(1);
				rf |= readback_refused;
				bs |= readback_busy;
			end
			run = 1'b0;
			readback_trigger = 1'b0;
			step(4);
			chk("refused", rf, s != 0);
			chk("started", bs, s == 0);
			chk("word", captured, 32'ha5c3_0f96);
		end
		uid_load = 1'b1;
		step(1);
		uid_load = 1'b0;
		step(1);
		chk("user id", user_id, 32'h1357_9bdf);
		for (int i = 0; i < 18; i++)
		begin
			rate_sel = i[4:0];
			step(3);
			chk("rate", internal_config_osc_mhz, i < PCS_RATE_NUM ? PCS_RATE_MHZ[i] : 6'h04);
		end
		report_and_stop();
	end
	initial
	begin
		#100us;
		n_mismatch++;
		report_and_stop();
	end
endmodule : pcs_startup_seq_bench
